/* File: common/dbc_pkg.sv */
// package: register map, field positions, reset values and timing counts
package dbc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int IRQ_W = 4;
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNTER = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam int CTL_HALT_BIT = 7;
  localparam int CTL_PCBRK_BIT = 3;
  localparam int CTL_ZBRK_BIT = 2;
  localparam int CTL_SRST_BIT = 0;
  localparam int ST_IDLE_BIT = 7;
  localparam int ST_HALT_BIT = 6;
  localparam int ST_RPROT_BIT = 5;
  localparam int IRQ_PC_HIT = 0;
  localparam int IRQ_ZERO_HIT = 1;
  localparam int IRQ_BREAK_OP = 2;
  localparam int IRQ_RST_DONE = 3;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] COUNTER_RST = 16'h0000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  localparam int CLK_PERIOD_NS = 10;
  localparam int POR_TIME_NS = 200;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    DBC_SEQ_IDLE = 3'b001,
    DBC_SEQ_HOLD = 3'b010,
    DBC_SEQ_DONE = 3'b100
  } dbc_seq_e;
endpackage : dbc_pkg

/* File: common/dbc_rst_if.sv */
// interface: handshake between debugger and device reset sequencer
`timescale 1ns/10ps
interface dbc_rst_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport seq (input start, output busy, output done);
endinterface : dbc_rst_if

/* File: rtl/dbc_reset_seq.sv */
// module: device reset sequencer that spares the debugger
`timescale 1ns/10ps
module dbc_reset_seq (
  input wire logic clock_in,
  input wire logic rst_in,
  dbc_rst_if.seq rst_if,
  output logic device_reset_out
);
  localparam logic [7:0] LAST = 8'(dbc_pkg::POR_CYCLES - 1);
  dbc_pkg::dbc_seq_e state;
  logic [7:0] cnt;

  // sequence state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state <= dbc_pkg::DBC_SEQ_IDLE;
    end else begin
      unique case (state)
        dbc_pkg::DBC_SEQ_IDLE: begin
          if (rst_if.start) begin
            state <= dbc_pkg::DBC_SEQ_HOLD;
          end
        end
        dbc_pkg::DBC_SEQ_HOLD: begin
          if (cnt == LAST) begin
            state <= dbc_pkg::DBC_SEQ_DONE;
          end
        end
        dbc_pkg::DBC_SEQ_DONE: begin
          state <= dbc_pkg::DBC_SEQ_IDLE;
        end
        default: begin
          state <= dbc_pkg::DBC_SEQ_IDLE;
        end
      endcase
    end
  end

  // hold length counter
  always_ff @(posedge clock_in) begin
    if (rst_in || state != dbc_pkg::DBC_SEQ_HOLD) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end

  // outputs
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      device_reset_out <= 1'b0;
      rst_if.busy <= 1'b0;
      rst_if.done <= 1'b0;
    end else begin
      device_reset_out <= (state == dbc_pkg::DBC_SEQ_IDLE && rst_if.start) ||
                          (state == dbc_pkg::DBC_SEQ_HOLD && cnt != LAST);
      rst_if.busy <= (state == dbc_pkg::DBC_SEQ_IDLE && rst_if.start) ||
                     state == dbc_pkg::DBC_SEQ_HOLD;
      rst_if.done <= state == dbc_pkg::DBC_SEQ_HOLD && cnt == LAST;
    end
  end
endmodule : dbc_reset_seq

/* File: rtl/dbc_top.sv */
// module: debugger breakpoint, counter, reset request and status block
// How it works
// R01: pc break select clear: debug counter counts down as ordinary counter.
// R02: pc break select set: debug counter holds a breakpoint address.
// R03: pc break mode: program counter equal to counter sets halt flag.
// R04: pc break select set: counter holds, no counting while cpu runs.
// R05: zero break enable: counter decrementing to zero sets halt flag.
// R06: zero break enable: counter kept, not cleared, when leaving halt.
// R07: writing one to self reset starts device reset; zero does nothing.
// R08: device reset runs full sequence; debugger state stays untouched.
// R09: self reset bit clears by hardware once reset sequence ends.
// R10: idle status reads halt flag or break opcode since control write.
// R11: halt status reads one while core is in low-power halt.
// R12: read protect status set when option bit is zero; refuses commands. The code refuses only counter writes.
// R13: reserved status and control bits read zero; host writes zero.
// R14: halt flag set stops cpu fetching; cleared lets it resume.
// R15: writes to debug status register are ignored.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
module dbc_top (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [15:0] pc_in,
  input wire logic cpu_step_in,
  input wire logic break_opcode_in,
  input wire logic halt_state_in,
  input wire logic read_protect_option_in,
  output logic debug_halt_flag_out,
  output logic device_reset_out,
  output logic irq_out
);
  localparam int SRST_MAX = dbc_pkg::POR_CYCLES + 4;

  dbc_rst_if rst_if ();

  logic halt_flag;
  logic pc_break_select;
  logic zero_break_enable;
  logic self_reset;
  logic break_seen;
  logic [15:0] counter;
  logic [3:0] irq_status;
  logic [3:0] irq_mask;
  logic [3:0] irq_event;
  logic [7:0] control_val;
  logic [7:0] status_val;
  logic [31:0] next_rdata;
  logic access;
  logic xfer;
  logic hit_ctl;
  logic hit_st;
  logic hit_cnt;
  logic hit_irq_st;
  logic hit_irq_mask;
  logic mapped;
  logic refuse;
  logic wr_en;
  logic wr_ctl;
  logic wr_cnt;
  logic rd_irq;
  logic running;
  logic pc_hit;
  logic cnt_step;
  logic zero_hit;
  logic leave;
  logic srst_req;

  // bus decode
  assign access = psel_in && penable_in;
  assign xfer = access && pready_out;
  assign hit_ctl = paddr_in == dbc_pkg::OFS_CONTROL;
  assign hit_st = paddr_in == dbc_pkg::OFS_STATUS;
  assign hit_cnt = paddr_in == dbc_pkg::OFS_COUNTER;
  assign hit_irq_st = paddr_in == dbc_pkg::OFS_IRQ_STATUS;
  assign hit_irq_mask = paddr_in == dbc_pkg::OFS_IRQ_MASK;
  assign mapped = hit_ctl || hit_st || hit_cnt || hit_irq_st || hit_irq_mask;
  // protected part refuses counter writes
  assign refuse = pwrite_in && hit_cnt && !read_protect_option_in; // R12
  assign wr_en = xfer && pwrite_in && !pslverr_out;
  assign wr_ctl = wr_en && hit_ctl;
  assign wr_cnt = wr_en && hit_cnt;
  assign rd_irq = xfer && !pwrite_in && hit_irq_st;

  // breakpoint and counter events
  assign running = !halt_flag;
  assign pc_hit = pc_break_select && running && pc_in == counter; // R03
  assign cnt_step = !pc_break_select && running && cpu_step_in && // R04
                    counter != 16'h0000;
  assign zero_hit = zero_break_enable && cnt_step && // R05
                    counter == 16'h0001;
  assign leave = wr_ctl && halt_flag && !pwdata_in[dbc_pkg::CTL_HALT_BIT];
  assign srst_req = wr_ctl && pwdata_in[dbc_pkg::CTL_SRST_BIT] &&
                    !self_reset;

  assign control_val = {halt_flag, 3'b000, pc_break_select,
                        zero_break_enable, 1'b0, self_reset}; // R13
  assign status_val = {halt_flag || break_seen, // R10
                       halt_state_in, // R11
                       !read_protect_option_in, // R12
                       5'b00000}; // R13
  assign irq_event = {rst_if.done, break_opcode_in, zero_hit, pc_hit};

  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_ctl) begin
      next_rdata = {24'h000000, control_val};
    end else if (hit_st) begin
      next_rdata = {24'h000000, status_val};
    end else if (hit_cnt) begin
      next_rdata = {16'h0000, counter};
    end else if (hit_irq_st) begin
      next_rdata = {28'h0000000, irq_status};
    end else if (hit_irq_mask) begin
      next_rdata = {28'h0000000, irq_mask};
    end
  end

  // apb answer: one wait state
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end else begin
      pready_out <= access && !pready_out;
      if (access && !pready_out) begin
        pslverr_out <= !mapped || refuse;
        prdata_out <= pwrite_in ? 32'h0000_0000 : next_rdata;
      end else begin
        pslverr_out <= 1'b0;
      end
    end
  end

  // halt flag
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      halt_flag <= dbc_pkg::CONTROL_RST[dbc_pkg::CTL_HALT_BIT];
    end else if (pc_hit || zero_hit) begin
      halt_flag <= 1'b1; // R03 R05
    end else if (wr_ctl) begin
      halt_flag <= pwdata_in[dbc_pkg::CTL_HALT_BIT]; // R14
    end
  end
  assign debug_halt_flag_out = halt_flag; // R14

  // break mode selects; status register writes fall through
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pc_break_select <= dbc_pkg::CONTROL_RST[dbc_pkg::CTL_PCBRK_BIT];
      zero_break_enable <= dbc_pkg::CONTROL_RST[dbc_pkg::CTL_ZBRK_BIT];
    end else if (wr_ctl) begin
      pc_break_select <= pwdata_in[dbc_pkg::CTL_PCBRK_BIT]; // R02
      zero_break_enable <= pwdata_in[dbc_pkg::CTL_ZBRK_BIT]; // R05
    end
  end

  // debug counter
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      counter <= dbc_pkg::COUNTER_RST;
    end else if (wr_cnt) begin
      counter <= pwdata_in[15:0];
    end else if (leave && !zero_break_enable) begin
      counter <= dbc_pkg::COUNTER_RST; // R06
    end else if (cnt_step) begin
      counter <= counter - 16'h0001; // R01
    end
  end

  // self reset request and hardware clear
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      self_reset <= dbc_pkg::CONTROL_RST[dbc_pkg::CTL_SRST_BIT];
      rst_if.start <= 1'b0;
    end else begin
      rst_if.start <= srst_req; // R07
      if (srst_req) begin
        self_reset <= 1'b1; // R07
      end else if (rst_if.done) begin
        self_reset <= 1'b0; // R09
      end
    end
  end

  // device reset drives the rest of the chip only
  dbc_reset_seq u_seq (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .rst_if(rst_if),
    .device_reset_out(device_reset_out) // R08
  );

  // break opcode seen since last control write
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      break_seen <= dbc_pkg::STATUS_RST[dbc_pkg::ST_IDLE_BIT];
    end else if (break_opcode_in) begin
      break_seen <= 1'b1; // R10
    end else if (wr_ctl) begin
      break_seen <= 1'b0; // R10
    end
  end

  // interrupt status, cleared by read, set wins
  genvar gi;
  generate
    for (gi = 0; gi < dbc_pkg::IRQ_W; gi++) begin : g_irq
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          irq_status[gi] <= 1'b0;
        end else if (irq_event[gi]) begin
          irq_status[gi] <= 1'b1;
        end else if (rd_irq) begin
          irq_status[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // interrupt mask and output
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      irq_mask <= dbc_pkg::IRQ_MASK_RST;
      irq_out <= 1'b0;
    end else begin
      if (wr_en && hit_irq_mask) begin
        irq_mask <= pwdata_in[3:0];
      end
      irq_out <= |(irq_status & irq_mask);
    end
  end

  // checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_status_read;
    access && !pready_out && hit_st && !pwrite_in;
  endsequence

  sequence s_srst_write;
    srst_req;
  endsequence

  sequence s_reset_runs;
    ##2 device_reset_out [*3];
  endsequence

  property p_count_down;
    !pc_break_select && running && cpu_step_in && counter != 16'h0000 &&
    !wr_cnt && !leave |=> counter == $past(counter) - 16'h0001;
  endproperty

  property p_status_bit(int b, logic v);
    s_status_read |=> prdata_out[b] == $past(v);
  endproperty

  AST_COUNT_MODE: assert property (p_count_down) // R01
    else $error("counter did not count down");

  AST_PC_BREAK: assert property ( // R02
    pc_break_select && running && pc_in == counter |=> halt_flag &&
    debug_halt_flag_out)
    else $error("pc match did not halt");

  AST_PC_HALT_MATCH: assert property ( // R03
    $rose(halt_flag) && !$past(wr_ctl) |->
    $past(pc_hit) || $past(zero_hit))
    else $error("halt flag set without a cause");

  AST_PC_HOLD: assert property ( // R04
    pc_break_select && !wr_cnt && !(leave && !zero_break_enable) |=>
    $stable(counter))
    else $error("counter moved in pc break mode");

  AST_ZERO_HALT: assert property ( // R05
    zero_hit && !wr_cnt |=> halt_flag && counter == 16'h0000)
    else $error("zero count did not halt");

  AST_ZERO_KEEP: assert property ( // R06
    zero_break_enable && leave && !wr_cnt |=> $stable(counter) &&
    !halt_flag)
    else $error("counter reinitialised on leaving halt");

  AST_ZERO_CLEAR: assert property ( // R06
    !zero_break_enable && leave && !wr_cnt |=> counter == 16'h0000)
    else $error("counter kept without zero break");

  AST_SRST_START: assert property ( // R07
    s_srst_write |-> s_reset_runs)
    else $error("self reset write did not reset device");

  AST_SRST_ZERO: assert property ( // R07
    wr_ctl && !pwdata_in[dbc_pkg::CTL_SRST_BIT] && !self_reset |=>
    !self_reset ##1 !device_reset_out)
    else $error("writing zero started a reset");

  AST_SRST_KEEP: assert property ( // R08
    device_reset_out && !wr_ctl && !wr_cnt && !cnt_step && !pc_hit &&
    !zero_hit |=> $stable(control_val[7:2]) && $stable(counter))
    else $error("debugger state lost during device reset");

  AST_SRST_BUSY: assert property ( // R08
    device_reset_out |-> rst_if.busy)
    else $error("device reset outside reset sequence");

  AST_SRST_CLEAR: assert property ( // R09
    $rose(self_reset) |-> ##[1:SRST_MAX] !self_reset)
    else $error("self reset bit never cleared");

  AST_SRST_DONE: assert property ( // R09
    rst_if.done |=> !self_reset && !device_reset_out)
    else $error("self reset bit not cleared at end");

  AST_IDLE: assert property ( // R10
    p_status_bit(dbc_pkg::ST_IDLE_BIT, halt_flag || break_seen))
    else $error("idle status wrong");

  AST_IDLE_BREAK: assert property ( // R10
    break_opcode_in ##1 !wr_ctl [*2] |=> break_seen)
    else $error("break opcode not remembered");

  AST_HALT_ST: assert property ( // R11
    p_status_bit(dbc_pkg::ST_HALT_BIT, halt_state_in))
    else $error("halt status wrong");

  AST_RPROT: assert property ( // R12
    p_status_bit(dbc_pkg::ST_RPROT_BIT, !read_protect_option_in))
    else $error("read protect status wrong");

  AST_RPROT_REFUSE: assert property ( // R12
    access && !pready_out && pwrite_in && hit_cnt &&
    !read_protect_option_in |=> pslverr_out ##1 $stable(counter))
    else $error("protected counter write not refused");

  AST_RESERVED: assert property ( // R13
    s_status_read |=> prdata_out[4:0] == 5'b00000 &&
    prdata_out[31:8] == 24'h000000)
    else $error("reserved status bits not zero");

  AST_CTL_RESERVED: assert property ( // R13
    access && !pready_out && hit_ctl && !pwrite_in |=>
    prdata_out[1] == 1'b0 && prdata_out[6:4] == 3'b000)
    else $error("reserved control bits not zero");

  AST_RESUME: assert property ( // R14
    leave |=> !debug_halt_flag_out)
    else $error("clearing halt flag did not resume");

  AST_STATUS_RO: assert property ( // R15
    wr_en && hit_st && !pc_hit && !zero_hit && !cnt_step &&
    !rst_if.done |=> $stable(control_val) && $stable(counter) &&
    $stable(irq_mask))
    else $error("status write changed state");

  AST_IRQ_LEVEL: assert property (
    |(irq_status & irq_mask) |=> irq_out)
    else $error("interrupt not raised");
endmodule : dbc_top

/* File: verif/dbc_cpu_model.sv */
// cpu model: steps the program counter while run_in is set, unless halted
`timescale 1ns/10ps
module dbc_cpu_model (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic halt_in,
  output logic [15:0] pc_out,
  output logic step_out
);
  // no fetch while the halt flag is up
  assign step_out = run_in & ~halt_in;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pc_out <= 16'h0000;
    end else if (step_out) begin
      pc_out <= pc_out + 16'h0001;
    end
  end
endmodule : dbc_cpu_model

/* File: verif/tb_top.sv */
// testbench: register access, breakpoints, status and reset request
`timescale 1ns/10ps
module tb_top;
  logic clock_in, rst_in, psel, penable, pwrite, break_opcode, halt_st, rp_opt, run;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, halt, dev_rst, irq, step, er;
  logic [15:0] pc, tgt;
  int error_cnt, compares, n;
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic e;
  } dbc_row_s;
  // write flag, address, write data, expected read data, expected error
  dbc_row_s rows[16] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h08, 32'h1234, 32'h0, 1'b0},
    '{1'b0, 8'h08, 32'h0, 32'h1234, 1'b0},
    '{1'b1, 8'h00, 32'h0C, 32'h0, 1'b0},
    '{1'b0, 8'h00, 32'h0, 32'h0C, 1'b0},
    '{1'b1, 8'h00, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h04, 32'hE0, 32'h0, 1'b0},
    '{1'b0, 8'h04, 32'h0, 32'h0, 1'b0},
    '{1'b1, 8'h14, 32'hFF, 32'h0, 1'b1},
    '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1},
    '{1'b1, 8'h10, 32'hFF, 32'h0, 1'b0},
    '{1'b0, 8'h10, 32'h0, 32'hF, 1'b0},
    '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b0}
  };

  dbc_top uut (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .psel_in(psel),
    .penable_in(penable),
    .pwrite_in(pwrite),
    .paddr_in(paddr),
    .pwdata_in(pwdata),
    .prdata_out(prdata),
    .pready_out(pready),
    .pslverr_out(pslverr),
    .pc_in(pc),
    .cpu_step_in(step),
    .break_opcode_in(break_opcode),
    .halt_state_in(halt_st),
    .read_protect_option_in(rp_opt),
    .debug_halt_flag_out(halt),
    .device_reset_out(dev_rst),
    .irq_out(irq)
  );

  dbc_cpu_model cpu (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .run_in(run),
    .halt_in(halt),
    .pc_out(pc),
    .step_out(step)
  );

  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  task automatic conclude();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer, waits for pready with no cycle limit
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clock_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_in);
    penable <= 1'b1;
    do begin
      @(posedge clock_in);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, x);
  endtask : rdc

  task automatic wait_halt();
    n = 0;
    while (halt !== 1'b1 && n < 200) begin
      @(posedge clock_in);
      n++;
    end
  endtask : wait_halt

  initial begin
    #500000;
    error_cnt++;
    conclude();
  end

  initial begin
    error_cnt = 0;
    compares = 0;
    rst_in = 1'b1;
    {psel, penable, pwrite, break_opcode, halt_st, run} = 6'h00;
    rp_opt = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      chk("apb err", {31'h0, er}, {31'h0, rows[i].e});
      if (!rows[i].w) chk("apb rdata", rd, rows[i].x);
    end
    // count down to zero with zero break
    xfer(1'b1, dbc_pkg::OFS_COUNTER, 32'h5);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h04);
    run <= 1'b1;
    wait_halt();
    chk("zero halt", {31'h0, halt}, 32'h1);
    rdc("zero cnt", dbc_pkg::OFS_COUNTER, 32'h0);
    tgt = pc;
    repeat (5) @(posedge clock_in);
    chk("pc hold", {16'h0, pc}, {16'h0, tgt});
    rdc("idle halt", dbc_pkg::OFS_STATUS, 32'h80);
    chk("irq up", {31'h0, irq}, 32'h1);
    rdc("irq zero", dbc_pkg::OFS_IRQ_STATUS, 32'h2);
    repeat (2) @(posedge clock_in);
    chk("irq down", {31'h0, irq}, 32'h0);
    run <= 1'b0;
    xfer(1'b1, dbc_pkg::OFS_COUNTER, 32'h7);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h04);
    rdc("cnt kept", dbc_pkg::OFS_COUNTER, 32'h7);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h80);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h00);
    rdc("cnt clear", dbc_pkg::OFS_COUNTER, 32'h0);
    // program counter breakpoint
    tgt = pc + 16'h0006;
    xfer(1'b1, dbc_pkg::OFS_COUNTER, {16'h0, tgt});
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h08);
    run <= 1'b1;
    wait_halt();
    chk("pc halt", {31'h0, halt}, 32'h1);
    rdc("pc cnt", dbc_pkg::OFS_COUNTER, {16'h0, tgt});
    rdc("irq pc", dbc_pkg::OFS_IRQ_STATUS, 32'h1);
    run <= 1'b0;
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h00);
    // break opcode, halt state, read protect
    break_opcode <= 1'b1;
    @(posedge clock_in);
    break_opcode <= 1'b0;
    rdc("idle brk", dbc_pkg::OFS_STATUS, 32'h80);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h00);
    rdc("idle clr", dbc_pkg::OFS_STATUS, 32'h0);
    rdc("irq brk", dbc_pkg::OFS_IRQ_STATUS, 32'h4);
    halt_st <= 1'b1;
    rp_opt <= 1'b0;
    rdc("halt prot", dbc_pkg::OFS_STATUS, 32'h60);
    xfer(1'b1, dbc_pkg::OFS_COUNTER, 32'h9);
    chk("prot err", {31'h0, er}, 32'h1);
    rdc("prot keep", dbc_pkg::OFS_COUNTER, 32'h0);
    halt_st <= 1'b0;
    rp_opt <= 1'b1;
    // self reset request
    xfer(1'b1, dbc_pkg::OFS_COUNTER, 32'h55);
    xfer(1'b1, dbc_pkg::OFS_IRQ_MASK, 32'h0);
    repeat (4) @(posedge clock_in);
    chk("no rst", {31'h0, dev_rst}, 32'h0);
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h01);
    n = 0;
    while (dev_rst !== 1'b1 && n < 10) begin
      @(posedge clock_in);
      n++;
    end
    chk("rst start", {31'h0, dev_rst}, 32'h1);
    n = 0;
    while (dev_rst === 1'b1 && n < 100) begin
      @(posedge clock_in);
      n++;
    end
    chk("rst len", n, dbc_pkg::POR_CYCLES);
    repeat (3) @(posedge clock_in);
    rdc("srst clr", dbc_pkg::OFS_CONTROL, 32'h0);
    rdc("cnt spared", dbc_pkg::OFS_COUNTER, 32'h55);
    chk("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, dbc_pkg::OFS_IRQ_MASK, 32'h8);
    repeat (2) @(posedge clock_in);
    chk("irq rst", {31'h0, irq}, 32'h1);
    rdc("irq done", dbc_pkg::OFS_IRQ_STATUS, 32'h8);
    repeat (2) @(posedge clock_in);
    chk("irq clr", {31'h0, irq}, 32'h0);
    // mid-run reset clears the debugger registers
    xfer(1'b1, dbc_pkg::OFS_CONTROL, 32'h84);
    xfer(1'b1, dbc_pkg::OFS_COUNTER, 32'h33);
    chk("halt set", {31'h0, halt}, 32'h1);
    rst_in <= 1'b1;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'b0;
    chk("rst halt", {31'h0, halt}, 32'h0);
    chk("rst dev", {31'h0, dev_rst}, 32'h0);
    chk("rst irq", {31'h0, irq}, 32'h0);
    rdc("rst ctl", dbc_pkg::OFS_CONTROL, 32'h0);
    rdc("rst cnt", dbc_pkg::OFS_COUNTER, 32'h0);
    conclude();
  end
endmodule : tb_top
